// ### tb_crosspoint_serial_programming.sv
// tb_crosspoint_serial_programming: host and device joined, plus a bench-driven device
`timescale 1ns/1ps
module tb_crosspoint_serial_programming;
   // ==========================================================
   // signals
   localparam logic [15:0] RAW_FRAME = 16'h0c61;  // frame shifted by the bench
   logic        clk_in;        // 200 MHz clock
   logic        rst_b_in;      // reset, active low
   logic        start_in;      // host transfer request
   logic        mode_in;       // 1 word, 0 frame
   logic [15:0] wdata_in;      // data to send
   logic        apply_in;      // apply request
   logic        reset_pin_in;  // reset pin level
   logic        broadcast_in;  // broadcast pin level
   logic        busy_out;      // host busy
   logic        done_out;      // host done pulse
   logic [15:0] rdata_out;     // bits seen on sdo
   logic [11:0] route_addr;    // joined device routing
   logic [3:0]  route_on;
   logic [11:0] route_addr_b;  // bench-driven device routing
   logic [3:0]  route_on_b;
   logic [11:0] m_addr;        // expected routing
   logic [3:0]  m_on;
   logic [15:0] w;             // addressed word
   int          error_cnt;
   int          checked;
   // ==========================================================
   // instances
   xps_if link();
   xps_if link_b();  // pins driven by the bench
   xps_host i_xps_host (.clk_in(clk_in), .rst_b_in(rst_b_in), .link(link),
      .start_in(start_in), .mode_in(mode_in), .wdata_in(wdata_in), .apply_in(apply_in),
      .reset_pin_in(reset_pin_in), .broadcast_in(broadcast_in), .busy_out(busy_out),
      .done_out(done_out), .rdata_out(rdata_out));
   xps_device i_xps_device (.clk_in(clk_in), .rst_b_in(rst_b_in), .link(link),
      .route_addr_out(route_addr), .route_on_out(route_on));
   xps_device i_xps_device_b (.clk_in(clk_in), .rst_b_in(rst_b_in), .link(link_b),
      .route_addr_out(route_addr_b), .route_on_out(route_on_b));
   xps_link_asserts i_xps_link_asserts (.clk_in(clk_in), .rst_b_in(rst_b_in),
      .sel_b(link.sel_b), .sclk(link.sclk), .sdi(link.sdi), .sdo(link.sdo),
      .apply(link.apply), .mode(link.mode), .rst_pin(link.rst_pin),
      .broadcast_all(link.broadcast_all), .route_addr_out(route_addr),
      .route_on_out(route_on));
   // ==========================================================
   // tasks
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   // expected routing from a frame: address lsb first, then off bit
   task automatic set_model(input logic [15:0] f);
      for (int k = 0; k < 4; k++)
      begin
         m_addr[3*k +: 3] = f[4*k +: 3];
         m_on[k] = ~f[4*k+3];
      end
   endtask : set_model
   task automatic check_route(input string what, input logic [11:0] a, input logic [3:0] o);
      check({what, " addr"}, {4'h0, m_addr}, {4'h0, a});
      check({what, " on"}, {12'h000, m_on}, {12'h000, o});
   endtask : check_route
   // one host transfer; wait for done under a bound
   task automatic send(input logic m, input logic [15:0] d);
      int n;
      @(posedge clk_in);
      start_in <= 1'b1;
      mode_in <= m;
      wdata_in <= d;
      @(posedge clk_in);
      start_in <= 1'b0;
      @(posedge clk_in);
      check("busy", 16'h0001, {15'h0000, busy_out});
      n = 0;
      while (done_out !== 1'b1 && n < 2000)
      begin
         @(posedge clk_in);
         n++;
      end
      check("done", 16'h0001, {15'h0000, done_out});
   endtask : send
   task automatic do_apply;
      @(posedge clk_in);
      apply_in <= 1'b1;
      @(posedge clk_in);
      apply_in <= 1'b0;
      repeat (20) @(posedge clk_in);
   endtask : do_apply
   // one 160 ns link clock; data valid only around the fall, inverted after
   task automatic raw_bit(input logic b);
      link_b.sclk <= 1'b1;
      repeat (8) @(posedge clk_in);
      link_b.sdi <= b;
      repeat (8) @(posedge clk_in);
      link_b.sclk <= 1'b0;
      repeat (8) @(posedge clk_in);
      link_b.sdi <= ~b;
      repeat (8) @(posedge clk_in);
   endtask : raw_bit
   task automatic raw_apply;
      link_b.apply <= 1'b1;
      repeat (4) @(posedge clk_in);
      link_b.apply <= 1'b0;
      repeat (12) @(posedge clk_in);
   endtask : raw_apply
   task automatic final_report;
      if (error_cnt == 0 && checked > 0)
      begin
         $display("ALL TESTS PASSED");
      end
      else
      begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : final_report
   // ==========================================================
   // clock and watchdog; the run needs about 3700 cycles
   initial
   begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end
   initial
   begin
      repeat (20000) @(posedge clk_in);
      error_cnt++;
      $display("[FAIL] watchdog expected finish seen hang");
      final_report();
   end
   // ==========================================================
   // main sequence
   initial
   begin
      error_cnt = 0;
      checked = 0;
      rst_b_in = 1'b0;
      start_in = 1'b0;
      mode_in = 1'b0;
      wdata_in = 16'h0000;
      apply_in = 1'b0;
      reset_pin_in = 1'b0;
      broadcast_in = 1'b0;
      link_b.sel_b = 1'b1;
      link_b.sclk = 1'b0;
      link_b.sdi = 1'b0;
      link_b.apply = 1'b0;
      link_b.mode = 1'b0;
      link_b.rst_pin = 1'b0;
      link_b.broadcast_all = 1'b0;
      repeat (10) @(posedge clk_in);
      rst_b_in <= 1'b1;
      @(posedge clk_in);
      set_model(16'h8888);
      check_route("reset", route_addr, route_on);
      send(1'b0, 16'h27b5);
      check_route("held a", route_addr, route_on);
      do_apply();
      set_model(16'h27b5);
      check_route("frame a", route_addr, route_on);
      send(1'b0, 16'h9c31);
      check("echo", 16'h27b5, rdata_out);
      check_route("held b", route_addr, route_on);
      do_apply();
      set_model(16'h9c31);
      check_route("frame b", route_addr, route_on);
      reset_pin_in <= 1'b1;
      repeat (10) @(posedge clk_in);
      set_model(16'h8888);
      check_route("rst pin", route_addr, route_on);
      reset_pin_in <= 1'b0;
      repeat (10) @(posedge clk_in);
      do_apply();
      check_route("stale apply", route_addr, route_on);
      broadcast_in <= 1'b1;
      repeat (10) @(posedge clk_in);
      set_model(16'h0000);
      check_route("broadcast_all", route_addr, route_on);
      broadcast_in <= 1'b0;
      repeat (10) @(posedge clk_in);
      // each output in turn; the others must keep their setting
      for (int k = 0; k < 4; k++)
      begin
         w = {10'h000, k == 2, 3'(k + 3), 2'(k)};
         send(1'b1, w);
         do_apply();
         m_addr[3*k +: 3] = w[4:2];
         m_on[k] = ~w[5];
         check_route("word", route_addr, route_on);
      end
      // bench-driven device: clocks while deselected must be ignored
      for (int i = 0; i < 16; i++) raw_bit(1'b1);
      raw_apply();
      set_model(16'h8888);
      check_route("unselected", route_addr_b, route_on_b);
      link_b.sel_b <= 1'b0;
      repeat (xps_pkg::SETUP_WAIT) @(posedge clk_in);
      for (int i = 0; i < 16; i++) raw_bit(RAW_FRAME[i]);
      raw_apply();
      set_model(RAW_FRAME);
      check_route("raw frame", route_addr_b, route_on_b);
      for (int i = 0; i < 16; i++) raw_bit(~RAW_FRAME[i]);
      link_b.sel_b <= 1'b1;
      link_b.apply <= 1'b1;
      repeat (16) @(posedge clk_in);
      set_model(~RAW_FRAME);
      check_route("three wire", route_addr_b, route_on_b);
      final_report();
   end
endmodule : tb_crosspoint_serial_programming

// ### xps_device.sv
// xps_device: crosspoint side of the serial programming link
`timescale 1ns/1ps
module xps_device
(
   // clock and reset
   input  wire logic                    clk_in,
   input  wire logic                    rst_b_in,
   // serial link
   xps_if.device                        link,
   // matrix control
   output logic [xps_pkg::NUM_OUT*3-1:0] route_addr_out,
   output logic [xps_pkg::NUM_OUT-1:0]   route_on_out
);
   // ==========================================================
   // declarations
   logic [xps_pkg::PIN_NUM-1:0]    pin_raw;    // pins as they arrive
   logic [xps_pkg::PIN_NUM-1:0]    pin_meta;   // first stage, read by stage two only
   logic [xps_pkg::PIN_NUM-1:0]    pin_s;      // synchronised pins
   logic                           sclk_d;     // clock one cycle back
   logic                           apply_d;    // apply one cycle back
   logic                           armed;      // receiver armed by a rise
   logic                           pending;    // bits shifted since last apply
   logic                           sdo_q;      // serial output flop
   logic [xps_pkg::FRAME_BITS-1:0] load_reg;   // load shift register
   logic [2:0]                     act_addr [xps_pkg::NUM_OUT]; // active input
   logic                           act_off  [xps_pkg::NUM_OUT]; // active off state

   // ==========================================================
   // decode of synchronised pins
   wire sel_low    = ~pin_s[xps_pkg::PIN_SEL];
   wire sclk_s     = pin_s[xps_pkg::PIN_CLK];
   wire din_s      = pin_s[xps_pkg::PIN_DIN];
   wire mode_s     = pin_s[xps_pkg::PIN_MODE];
   wire rstpin_s   = pin_s[xps_pkg::PIN_RST];
   wire bc_s       = pin_s[xps_pkg::PIN_BC];
   wire sclk_rise  = sclk_s & ~sclk_d;
   wire sclk_fall  = ~sclk_s & sclk_d;
   wire apply_rise = pin_s[xps_pkg::PIN_APPLY] & ~apply_d;
   // capture only when armed and selected
   wire capture    = sclk_fall & armed & sel_low;   // RQ2 RQ3 RQ1
   wire apply_go   = apply_rise & pending;          // RQ9 RQ10 RQ11
   // new bits enter at the top so the first lands at bit zero
   wire [xps_pkg::FRAME_BITS-1:0] next_load =
      {din_s, load_reg[xps_pkg::FRAME_BITS-1:1]};   // RQ14 RQ15
   // fields of an addressed word as it sits in the load register
   wire [1:0] word_out = load_reg[xps_pkg::WORD_BASE+xps_pkg::WORD_OUT_POS +: 2]; // RQ20
   wire [2:0] word_in  = load_reg[xps_pkg::WORD_BASE+xps_pkg::WORD_IN_POS +: 3];
   wire       word_off = load_reg[xps_pkg::WORD_BASE+xps_pkg::WORD_OFF_POS];

   assign pin_raw = {link.broadcast_all, link.rst_pin, link.mode, link.apply,
                     link.sdi, link.sclk, link.sel_b};

   // ==========================================================
   // two-stage synchroniser, all pins come from outside
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         pin_meta <= 7'h01;   // select idles high
         pin_s    <= 7'h01;
      end
      else
      begin
         pin_meta <= pin_raw;
         pin_s    <= pin_meta;
      end
   end

   // ==========================================================
   // edge history for clock and apply
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         sclk_d  <= 1'b0;
         apply_d <= 1'b0;
      end
      else
      begin
         sclk_d  <= sclk_s;
         apply_d <= pin_s[xps_pkg::PIN_APPLY];
      end
   end

   // ==========================================================
   // arming: a rise while selected opens the receiver
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         armed <= 1'b0;
      else if (!sel_low)
         armed <= 1'b0;                  // RQ1
      else if (sclk_rise)
         armed <= 1'b1;                  // RQ2
   end

   // ==========================================================
   // load shift register and serial output
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         load_reg <= 16'h0000;
         sdo_q    <= 1'b0;
      end
      else
      begin
         if (capture)
            load_reg <= next_load;       // RQ3 RQ13 RQ15
         // oldest bit leaves on the rise so a chained part samples it on the fall
         if (sclk_rise && sel_low)
            sdo_q <= load_reg[0];        // RQ23 RQ15
      end
   end

   // ==========================================================
   // new-data flag; a bit arriving with the apply edge keeps it set
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         pending <= 1'b0;
      else if (capture)
         pending <= 1'b1;                // set wins over clear
      else if (apply_go || rstpin_s)
         pending <= 1'b0;                // RQ11
   end

   // ==========================================================
   // active registers: reset pin beats broadcast beats apply
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         for (int k = 0; k < xps_pkg::NUM_OUT; k++)
         begin
            act_addr[k] <= xps_pkg::RST_ADDR;
            act_off[k]  <= xps_pkg::RST_OFF;
         end
      end
      else if (rstpin_s)
      begin
         for (int k = 0; k < xps_pkg::NUM_OUT; k++)
         begin
            act_addr[k] <= xps_pkg::RST_ADDR;   // RQ21
            act_off[k]  <= xps_pkg::RST_OFF;
         end
      end
      else if (bc_s)
      begin
         for (int k = 0; k < xps_pkg::NUM_OUT; k++)
         begin
            act_addr[k] <= xps_pkg::BC_ADDR;    // RQ22
            act_off[k]  <= 1'b0;
         end
      end
      else if (apply_go)
      begin
         if (mode_s)
         begin
            // addressed word touches only the named output
            act_addr[word_out] <= word_in;      // RQ12 RQ20
            act_off[word_out]  <= word_off;
         end
         else
         begin
            for (int k = 0; k < xps_pkg::NUM_OUT; k++)
            begin
               act_addr[k] <= load_reg[k*xps_pkg::GRP_W +: 3];     // RQ13 RQ19
               act_off[k]  <= load_reg[k*xps_pkg::GRP_W + xps_pkg::GRP_OFF_POS];
            end
         end
      end
   end

   // ==========================================================
   // outputs straight from the active flops, never from the bus
   generate
      for (genvar g = 0; g < xps_pkg::NUM_OUT; g++)
      begin : g_out
         assign route_addr_out[g*3 +: 3] = act_addr[g];   // RQ8
         assign route_on_out[g]          = ~act_off[g];
      end
   endgenerate

   assign link.sdo = sdo_q;

endmodule : xps_device

// ### xps_host.sv
// xps_host: controller side that drives the serial programming pins
`timescale 1ns/1ps
module xps_host
(
   // clock and reset
   input  wire logic                           clk_in,
   input  wire logic                           rst_b_in,
   // serial link
   xps_if.host                                 link,
   // user requests
   input  wire logic                           start_in,
   input  wire logic                           mode_in,
   input  wire logic [xps_pkg::FRAME_BITS-1:0] wdata_in,
   input  wire logic                           apply_in,
   input  wire logic                           reset_pin_in,
   input  wire logic                           broadcast_in,
   // user status
   output logic                                busy_out,
   output logic                                done_out,
   output logic [xps_pkg::FRAME_BITS-1:0]      rdata_out
);
   // ==========================================================
   // states, gray along idle, setup, shift, finish
   typedef enum logic [1:0] {
      XPS_IDLE  = 2'b00,
      XPS_SETUP = 2'b01,
      XPS_SHIFT = 2'b11,
      XPS_FIN   = 2'b10
   } xps_state_t;

   xps_state_t                     state;      // sequencer state
   logic [4:0]                     div;        // divider and wait counter
   logic [xps_pkg::CNT_W-1:0]      cnt;        // bits completed
   logic [xps_pkg::CNT_W-1:0]      nbits;      // bits in this transfer
   logic [xps_pkg::FRAME_BITS-1:0] shreg;      // data being sent
   logic [3:0]                     acnt;       // apply pulse counter
   logic                           sdo_meta;   // first stage, stage two only
   logic                           sdo_s;      // synchronised serial output
   logic                           sel_b_q, sclk_q, sdi_q, apply_q, mode_q;
   logic                           rst_q, bc_q;

   wire half_end  = (div == 5'(xps_pkg::SCLK_HALF_CYC - 1));
   wire setup_end = (div == 5'(xps_pkg::SETUP_WAIT - 1));
   wire last_bit  = (cnt == nbits - 5'd1);
   wire idle      = (state == XPS_IDLE) && (acnt == 4'h0);
   wire apply_end = (acnt == 4'(xps_pkg::APPLY_CYC));

   // ==========================================================
   // serial output from the device crosses in by two flops
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         sdo_meta <= 1'b0;
         sdo_s    <= 1'b0;
      end
      else
      begin
         sdo_meta <= link.sdo;
         sdo_s    <= sdo_meta;
      end
   end

   // ==========================================================
   // level pins just follow their requests
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         rst_q  <= 1'b0;
         bc_q   <= 1'b0;
      end
      else
      begin
         rst_q  <= reset_pin_in;     // RQ21
         bc_q   <= broadcast_in;     // RQ22
      end
   end

   // ==========================================================
   // transfer sequencer with clock divider
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         state     <= XPS_IDLE;
         div       <= 5'h00;
         cnt       <= 5'h00;
         nbits     <= 5'h00;
         shreg     <= 16'h0000;
         sel_b_q   <= 1'b1;
         sclk_q    <= 1'b0;
         sdi_q     <= 1'b0;
         mode_q    <= 1'b0;
         done_out  <= 1'b0;
         rdata_out <= 16'h0000;
      end
      else
      begin
         done_out <= 1'b0;
         case (state)
            XPS_IDLE:
            begin
               // starts refused while an apply pulse is out
               if (start_in && acnt == 4'h0)
               begin
                  shreg   <= wdata_in;
                  mode_q  <= mode_in;
                  nbits   <= mode_in ? 5'(xps_pkg::WORD_BITS) : 5'(xps_pkg::FRAME_BITS);
                  sdi_q   <= wdata_in[0];          // RQ14
                  sel_b_q <= 1'b0;                 // RQ4
                  cnt     <= 5'h00;
                  div     <= 5'h00;
                  state   <= XPS_SETUP;
               end
            end
            XPS_SETUP:
            begin
               // select settles before the first rise
               div <= div + 5'd1;
               if (setup_end)
               begin
                  div   <= 5'h00;
                  state <= XPS_SHIFT;              // RQ4
               end
            end
            XPS_SHIFT:
            begin
               div <= div + 5'd1;
               if (half_end)
               begin
                  div <= 5'h00;
                  if (!sclk_q)
                  begin
                     // data changes on the rise, a half period before its sample
                     sclk_q <= 1'b1;
                     sdi_q  <= shreg[cnt[3:0]];
                  end
                  else
                  begin
                     sclk_q    <= 1'b0;
                     cnt       <= cnt + 5'd1;
                     rdata_out <= {sdo_s, rdata_out[xps_pkg::FRAME_BITS-1:1]};
                     if (last_bit)
                        state <= XPS_FIN;          // RQ7
                  end
               end
            end
            XPS_FIN:
            begin
               // select rises with the clock low, long before any rise
               div <= div + 5'd1;
               if (half_end)
               begin
                  div      <= 5'h00;
                  sel_b_q  <= 1'b1;                // RQ5 RQ6
                  done_out <= 1'b1;
                  state    <= XPS_IDLE;
               end
            end
            default:
               state <= XPS_IDLE;
         endcase
      end
   end

   // ==========================================================
   // apply pulse only while nothing is shifting
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         acnt    <= 4'h0;
         apply_q <= 1'b0;
      end
      else if (acnt != 4'h0)
      begin
         acnt <= apply_end ? 4'h0 : acnt + 4'h1;
         if (apply_end)
            apply_q <= 1'b0;
      end
      else if (apply_in && state == XPS_IDLE && !start_in)
      begin
         acnt    <= 4'h1;
         apply_q <= 1'b1;                          // RQ16 RQ18
      end
   end

   // ==========================================================
   // pins from flops
   assign link.sel_b         = sel_b_q;
   assign link.sclk          = sclk_q;
   assign link.sdi           = sdi_q;
   assign link.apply         = apply_q;
   assign link.mode          = mode_q;
   assign link.rst_pin       = rst_q;
   assign link.broadcast_all = bc_q;
   assign busy_out           = ~idle;

endmodule : xps_host

// ### xps_if.sv
// xps_if: serial programming pins between controller and crosspoint
`timescale 1ns/1ps
interface xps_if;
   logic sel_b;         // select, active low
   logic sclk;          // serial clock from controller
   logic sdi;           // serial data into device
   logic sdo;           // serial data out of device
   logic apply;         // apply configuration strobe
   logic mode;          // high: addressed word, low: full frame
   logic rst_pin;       // level reset of active registers
   logic broadcast_all; // level broadcast of input zero

   modport device (input sel_b, sclk, sdi, apply, mode, rst_pin, broadcast_all,
                   output sdo);
   modport host   (output sel_b, sclk, sdi, apply, mode, rst_pin, broadcast_all,
                   input sdo);
endinterface : xps_if

// ### xps_link_asserts.sv
// xps_link_asserts: timing checks on the link between host and device
`timescale 1ns/1ps
module xps_link_asserts
(
   // clock and reset
   input wire logic                          clk_in,
   input wire logic                          rst_b_in,
   // link pins
   input wire logic                          sel_b,
   input wire logic                          sclk,
   input wire logic                          sdi,
   input wire logic                          sdo,
   input wire logic                          apply,
   input wire logic                          mode,
   input wire logic                          rst_pin,
   input wire logic                          broadcast_all,
   // matrix outputs
   input wire logic [xps_pkg::NUM_OUT*3-1:0] route_addr_out,
   input wire logic [xps_pkg::NUM_OUT-1:0]   route_on_out
);
   // ==========================================================
   // helper counters
   logic       sclk_q;        // sclk one cycle back
   logic [3:0] rise_age;      // cycles since sclk rose
   logic [3:0] quiet_cnt;     // cycles since any control strobe
   wire        sclk_rise = sclk & ~sclk_q;                   // rising link clock
   wire        strobe    = apply | rst_pin | broadcast_all;  // may rewrite routing
   // counters saturate so an old event never wraps back into the window
   wire  [3:0] next_rise_age  = sclk_rise ? 4'h0 : rise_age + {3'h0, rise_age != 4'hf};
   wire  [3:0] next_quiet_cnt = strobe ? 4'h0 : quiet_cnt + {3'h0, quiet_cnt != 4'hf};
   // edge tracker and counters
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         sclk_q    <= 1'b0;
         rise_age  <= 4'hf;
         quiet_cnt <= 4'h0;
      end
      else
      begin
         sclk_q    <= sclk;
         rise_age  <= next_rise_age;
         quiet_cnt <= next_quiet_cnt;
      end
   end
   // ==========================================================
   // assertions
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   sequence clk_quiet;
      !sclk [*8];
   endsequence
   sequence apply_body;
      apply [*8] ##1 !apply;
   endsequence
   sel_setup_a: assert property ($fell(sel_b) |-> clk_quiet)
      else $error("link clock rose too soon after select");
   clk_gated_a: assert property (sel_b |-> !sclk)
      else $error("link clock high while deselected");
   sel_end_a: assert property ($rose(sel_b) |-> !sclk && !$past(sclk, 8))
      else $error("select raised too close to a clock edge");
   apply_gap_a: assert property (apply |-> sel_b)
      else $error("apply raised during a transfer");
   apply_pulse_a: assert property ($rose(apply) |-> apply_body)
      else $error("apply pulse width wrong");
   route_hold_a: assert property (quiet_cnt > 4'h8 |-> $stable(route_addr_out)
      && $stable(route_on_out))
      else $error("routing changed without apply");
   reset_pin_a: assert property (rst_pin [*6] |-> route_on_out == '0
      && route_addr_out == '0)
      else $error("reset pin did not clear routing");
   bc_pin_a: assert property ((broadcast_all && !rst_pin) [*6] |-> route_on_out == '1
      && route_addr_out == '0)
      else $error("broadcast did not route input zero");
   sdo_edge_a: assert property (!$stable(sdo) |-> rise_age < 4'h6)
      else $error("serial out moved away from a rising edge");
endmodule : xps_link_asserts

// ### xps_pkg.sv
// xps_pkg: shared constants for the crosspoint serial programming link
// Functional notes
// RQ1: select is active low; ignore pins while high
// RQ2: arm on first rise, capture on next fall
// RQ3: sample every data bit on falling clock edge
// RQ4: controller lowers select before first rising edge
// RQ5: controller ends transfer by select or stopped clock
// RQ6: select rises after last sample, before next rise
// RQ7: or exact pulse count, clock idle low around
// RQ8: per-output active registers, not bus writable
// RQ9: apply pin alone copies load into active registers
// RQ10: apply and mode work regardless of select
// RQ11: apply without new bits changes nothing
// RQ12: mode high: addressed word updates one output
// RQ13: mode low: 16-bit frame sets all outputs
// RQ14: first bit shifted in is bit zero
// RQ15: extra clocks keep shifting, old bits out serially
// RQ16: controller holds apply low until shifting done
// RQ17: three-wire: apply tied to select, clock gated
// RQ18: four-wire: preload devices, one common apply
// RQ19: frame: four groups, address lsb first, off bit
// RQ20: word: output address, input address, off bit
// RQ21: reset pin: address zero, all outputs off
// RQ22: broadcast pin: all outputs on, input zero
// RQ23: serial output updates on rising clock edge
package xps_pkg;
   // ==========================================================
   // matrix geometry and frame layout
   localparam int NUM_OUT     = 4;   // outputs of the matrix
   localparam int IN_W        = 3;   // input address width
   localparam int OUT_W       = 2;   // output address width
   localparam int GRP_W       = 4;   // bits per output group in a frame
   localparam int GRP_OFF_POS = 3;   // off bit inside a group
   localparam int FRAME_BITS  = 16;  // serial mode frame length
   localparam int WORD_BITS   = 6;   // addressed mode word length
   localparam int WORD_BASE   = FRAME_BITS - WORD_BITS; // word lsb in load reg
   localparam int WORD_OUT_POS = 0;  // output address in word
   localparam int WORD_IN_POS  = 2;  // input address in word
   localparam int WORD_OFF_POS = 5;  // off bit in word
   localparam int CNT_W        = 5;  // bit counter width
   // ==========================================================
   // reset and broadcast values of the active registers
   localparam logic [2:0] RST_ADDR = 3'h0;
   localparam logic       RST_OFF  = 1'b1;
   localparam logic [2:0] BC_ADDR  = 3'h0;
   // ==========================================================
   // synchroniser lanes for device pins
   localparam int PIN_SEL   = 0;
   localparam int PIN_CLK   = 1;
   localparam int PIN_DIN   = 2;
   localparam int PIN_APPLY = 3;
   localparam int PIN_MODE  = 4;
   localparam int PIN_RST   = 5;
   localparam int PIN_BC    = 6;
   localparam int PIN_NUM   = 7;
   localparam int SYNC_STAGES = 2;
   // ==========================================================
   // timing
   localparam int CLK_NS        = 5;   // system clock period
   localparam int CS_SETUP_NS   = 5;   // select low before first rise
   localparam int CS_SETUP_CYC  = (CS_SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int SETUP_WAIT    = CS_SETUP_CYC + SYNC_STAGES + 1;
   localparam int SCLK_HALF_CYC = 16;  // half period of generated clock
   localparam int APPLY_CYC     = 8;   // apply pulse width
endpackage : xps_pkg
